/* File: lat_pkg.sv */
package lat_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NSIG = 8;
    localparam int BW = 8;
    localparam int PAW = 8;
    localparam int PATW = 3;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PATTERN = 8'h08;
    localparam logic [7:0] OFS_BUSMATCH = 8'h0C;
    localparam logic [7:0] OFS_GROUP = 8'h10;
    localparam logic [7:0] OFS_ADVANCED = 8'h14;
    localparam logic [7:0] OFS_FUNCADDR = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN = 8'h24;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_START = 0;
    localparam int CTRL_BYPASS = 1;
    localparam int CTRL_MODE = 2;
    localparam int CTRL_ABORT = 5;
    localparam int STAT_ARMED = 0;
    localparam int STAT_DONE = 1;
    localparam int BM_CARE = 8;
    localparam int GRP_LEAF1 = 3;
    localparam int GRP_ROOT = 6;
    localparam int ADV_BITOP = 3;
    localparam int ADV_SDIR = 5;
    localparam int ADV_SAMT = 7;
    localparam int ADV_RED = 10;
    localparam int ADV_DPAT = 12;
    localparam int ADV_DSEL = 15;
    localparam int ADV_COMB = 18;
    localparam int ADV_NOT = 20;
    localparam int IRQ_TRIG = 0;
    localparam int IRQ_START = 1;
    localparam int NIRQ = 2;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [2:0] MODE_AND = 3'h0;
    localparam logic [2:0] MODE_OR = 3'h1;
    localparam logic [2:0] MODE_GROUP = 3'h2;
    localparam logic [2:0] MODE_ADV = 3'h3;
    localparam logic [2:0] MODE_ADDR = 3'h4;
    localparam logic [2:0] PAT_DC = 3'h0;
    localparam logic [2:0] PAT_LOW = 3'h1;
    localparam logic [2:0] PAT_HIGH = 3'h2;
    localparam logic [2:0] PAT_FALL = 3'h3;
    localparam logic [2:0] PAT_RISE = 3'h4;
    localparam logic [2:0] PAT_EDGE = 3'h5;
    localparam logic [2:0] GOP_AND = 3'h0;
    localparam logic [2:0] GOP_OR = 3'h1;
    localparam logic [2:0] GOP_NAND = 3'h2;
    localparam logic [2:0] GOP_NOR = 3'h3;
    localparam logic [2:0] GOP_XOR = 3'h4;
    localparam logic [2:0] GOP_XNOR = 3'h5;
    localparam logic [2:0] GOP_TRUE = 3'h6;
    localparam logic [2:0] GOP_FALSE = 3'h7;
    localparam logic [8:0] GROUP_RST = 9'h1FF;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_DONE} lat_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [PAW-1:0] paddr;
        logic [31:0] pwdata;
    } lat_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } lat_apb_rsp_s;

    typedef struct packed {
        logic [NSIG-1:0] probe;
        logic [BW-1:0] bus_a;
        logic [BW-1:0] bus_b;
        logic [31:0] iaddr;
        logic iaddr_valid;
        logic qual;
    } lat_tap_s;

endpackage

/* File: lat_trigger_eval.sv */
// What this block does
// [R1] run-time bypass stores every armed sample except the triggering one, whatever the qualifier
// [R2] sample while armed, stop on trigger
// [R3] per-signal pattern: ignore, low, high, edges
// [R4] masked bus bits never affect bus match
// [R5] AND mode fires when all patterns hold
// [R6] leaf group results feed parent group
// [R7] forced true group outputs one
// [R8] forced false group outputs zero
// [R9] group reduction AND OR NAND NOR XOR XNOR
// [R10] plain AND/OR only on leaf groups
// [R11] bus compare lt le eq ne gt ge
// [R12] logical, reduction, shift, bitwise, detector tree
// [R13] fire when instruction address equals function
// [R14] evaluate every cycle, independent of qualifier
// [R15] restart reinitialises trigger logic
// [R16] edges use previous registered sample
// [R17] settings held in loadable registers
`timescale 1ns/100ps
`default_nettype none

module lat_trigger_eval import lat_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire lat_apb_req_s apb_req,
    output var lat_apb_rsp_s apb_rsp,
    input wire lat_tap_s tap,
    output logic trig_out,
    output logic store_en,
    output logic armed,
    output logic irq
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        lat_state_e st;
        logic bypass;
        logic [2:0] mode;
        logic [NSIG*PATW-1:0] pat;
        logic [BW-1:0] busv;
        logic [BW-1:0] care;
        logic [8:0] grp;
        logic [20:0] adv;
        logic [31:0] faddr;
        logic [NIRQ-1:0] ien;
        logic [NIRQ-1:0] ist;
        logic [NSIG-1:0] prev;
        logic prev_ok;
        logic trig;
        logic arm;
        logic store;
        logic irq;
        lat_apb_rsp_s rsp;
    } lat_reg_s;

    lat_reg_s s_q;
    lat_reg_s s_d;

    // ************************************************************
    // helpers
    // ************************************************************
    // one signal against one pattern code
    function automatic logic pat_hit(input logic [2:0] p, input logic c,
                                     input logic o, input logic ok);
        logic r;
        r = 1'b0;
        case (p)
            PAT_DC: r = 1'b1;
            PAT_LOW: r = ~c;
            PAT_HIGH: r = c;
            PAT_FALL: r = ok & o & ~c; // see [R16]
            PAT_RISE: r = ok & ~o & c; // see [R16]
            PAT_EDGE: r = ok & (o ^ c); // see [R16]
            default: r = 1'b0;
        endcase
        return r; // see [R3]
    endfunction

    // group reduction over four members, or two for the root
    function automatic logic grp_red(input logic [2:0] op, input logic [3:0] v,
                                     input logic two);
        logic a;
        logic o;
        logic x;
        logic r;
        a = two ? &v[1:0] : &v;
        o = two ? |v[1:0] : |v;
        x = two ? ^v[1:0] : ^v;
        r = 1'b0;
        case (op)
            GOP_AND: r = a & ~two; // see [R10]
            GOP_OR: r = o & ~two; // see [R10]
            GOP_NAND: r = ~a; // see [R9]
            GOP_NOR: r = ~o; // see [R9]
            GOP_XOR: r = x; // see [R9]
            GOP_XNOR: r = ~x; // see [R9]
            GOP_TRUE: r = 1'b1; // see [R7]
            GOP_FALSE: r = 1'b0; // see [R8]
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // ************************************************************
    // basic patterns
    // ************************************************************
    logic [NSIG-1:0] sig_hit;

    // one matcher per monitored signal
    genvar gi;
    generate
        for (gi = 0; gi < NSIG; gi++) begin : g_sig
            assign sig_hit[gi] = pat_hit(s_q.pat[gi*PATW +: PATW], tap.probe[gi],
                                         s_q.prev[gi], s_q.prev_ok); // see [R3]
        end
    endgenerate

    logic bus_hit;
    logic basic_and;
    logic basic_or;

    // masked bus match joins the basic terms
    assign bus_hit = ~|((tap.bus_a ^ s_q.busv) & s_q.care); // see [R4]
    assign basic_and = (&sig_hit) & bus_hit; // see [R5]
    assign basic_or = (|sig_hit) | (bus_hit & (|s_q.care));

    // ************************************************************
    // nested groups
    // ************************************************************
    logic leaf0;
    logic leaf1;
    logic root;

    // leaves first, then their results into the root
    assign leaf0 = grp_red(s_q.grp[2:0], sig_hit[3:0], 1'b0); // see [R6]
    assign leaf1 = grp_red(s_q.grp[5:3], sig_hit[7:4], 1'b0); // see [R6]
    assign root = grp_red(s_q.grp[8:6], {2'h0, leaf1, leaf0}, 1'b1); // see [R6]

    // ************************************************************
    // advanced expression tree
    // ************************************************************
    logic cmp_r;
    logic [BW-1:0] sh;
    logic [BW-1:0] bw;
    logic red_r;
    logic det_r;
    logic ab;
    logic adv_r;
    logic [2:0] dsel;

    assign dsel = s_q.adv[ADV_DSEL +: 3];

    // comparison, shift, bitwise, reduction and detector nodes
    always_comb begin
        cmp_r = 1'b0;
        case (s_q.adv[2:0])
            3'h0: cmp_r = tap.bus_a < tap.bus_b; // see [R11]
            3'h1: cmp_r = tap.bus_a <= tap.bus_b; // see [R11]
            3'h2: cmp_r = tap.bus_a == tap.bus_b; // see [R11]
            3'h3: cmp_r = tap.bus_a != tap.bus_b; // see [R11]
            3'h4: cmp_r = tap.bus_a > tap.bus_b; // see [R11]
            3'h5: cmp_r = tap.bus_a >= tap.bus_b; // see [R11]
            default: cmp_r = 1'b0;
        endcase
        case (s_q.adv[ADV_SDIR +: 2])
            2'h1: sh = tap.bus_a << s_q.adv[ADV_SAMT +: 3]; // see [R12]
            2'h2: sh = tap.bus_a >> s_q.adv[ADV_SAMT +: 3]; // see [R12]
            default: sh = tap.bus_a;
        endcase
        case (s_q.adv[ADV_BITOP +: 2])
            2'h0: bw = ~sh; // see [R12]
            2'h1: bw = sh & tap.bus_b; // see [R12]
            2'h2: bw = sh | tap.bus_b; // see [R12]
            default: bw = sh ^ tap.bus_b; // see [R12]
        endcase
        case (s_q.adv[ADV_RED +: 2])
            2'h0: red_r = &bw; // see [R12]
            2'h1: red_r = |bw; // see [R12]
            default: red_r = ^bw; // see [R12]
        endcase
        det_r = pat_hit(s_q.adv[ADV_DPAT +: 3], tap.probe[dsel],
                        s_q.prev[dsel], s_q.prev_ok); // see [R12]
        case (s_q.adv[ADV_COMB +: 2])
            2'h0: ab = cmp_r & red_r;
            2'h1: ab = cmp_r | red_r;
            default: ab = cmp_r ^ red_r;
        endcase
        case (s_q.adv[ADV_COMB +: 2])
            2'h0: adv_r = ab & det_r;
            2'h1: adv_r = ab | det_r;
            default: adv_r = ab ^ det_r;
        endcase
        adv_r = adv_r ^ s_q.adv[ADV_NOT]; // see [R12]
    end

    // ************************************************************
    // trigger select
    // ************************************************************
    logic addr_hit;
    logic cond;

    assign addr_hit = tap.iaddr_valid & (tap.iaddr == s_q.faddr); // see [R13]

    // chosen condition, independent of the qualifier input
    always_comb begin
        case (s_q.mode)
            MODE_AND: cond = basic_and; // see [R14]
            MODE_OR: cond = basic_or; // see [R14]
            MODE_GROUP: cond = root; // see [R14]
            MODE_ADV: cond = adv_r; // see [R14]
            MODE_ADDR: cond = addr_hit; // see [R13]
            default: cond = 1'b0;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    logic wr;
    logic rd;
    logic [31:0] rdat;
    logic err;
    logic [NIRQ-1:0] ev;
    logic [NIRQ-1:0] clr;
    logic [2:0] root_op;

    always_comb begin
        s_d = s_q;
        ev = '0;
        clr = '0;
        rdat = 32'h0;
        err = 1'b0;
        root_op = apb_req.pwdata[GRP_ROOT +: 3];
        wr = apb_req.psel & apb_req.penable & ~s_q.rsp.pready & apb_req.pwrite;
        rd = apb_req.psel & apb_req.penable & ~s_q.rsp.pready & ~apb_req.pwrite;
        // sampling and trigger while armed
        if (s_q.st == ST_ARMED) begin
            s_d.prev = tap.probe; // see [R16]
            s_d.prev_ok = 1'b1;
            if (cond) begin
                s_d.st = ST_DONE; // see [R2]
                ev[IRQ_TRIG] = 1'b1;
            end
        end
        // register writes
        if (wr) begin
            if (apb_req.paddr == OFS_CTRL) begin
                s_d.bypass = apb_req.pwdata[CTRL_BYPASS]; // see [R1]
                s_d.mode = apb_req.pwdata[CTRL_MODE +: 3]; // see [R17]
                if (apb_req.pwdata[CTRL_ABORT]) begin
                    s_d.st = ST_IDLE;
                end else if (apb_req.pwdata[CTRL_START]) begin
                    s_d.st = ST_ARMED; // see [R15]
                    s_d.prev_ok = 1'b0; // see [R15]
                    ev[IRQ_START] = 1'b1;
                end
            end else if (apb_req.paddr == OFS_PATTERN) begin
                s_d.pat = apb_req.pwdata[NSIG*PATW-1:0]; // see [R17]
            end else if (apb_req.paddr == OFS_BUSMATCH) begin
                s_d.busv = apb_req.pwdata[BW-1:0];
                s_d.care = apb_req.pwdata[BM_CARE +: BW];
            end else if (apb_req.paddr == OFS_GROUP) begin
                s_d.grp[5:0] = apb_req.pwdata[5:0];
                // plain AND/OR at the root fall back to false
                s_d.grp[8:6] = (root_op == GOP_AND || root_op == GOP_OR) ?
                               GOP_FALSE : root_op; // see [R10]
            end else if (apb_req.paddr == OFS_ADVANCED) begin
                s_d.adv = apb_req.pwdata[20:0];
            end else if (apb_req.paddr == OFS_FUNCADDR) begin
                s_d.faddr = apb_req.pwdata;
            end else if (apb_req.paddr == OFS_IRQ_CLR) begin
                clr = apb_req.pwdata[NIRQ-1:0];
            end else if (apb_req.paddr == OFS_IRQ_EN) begin
                s_d.ien = apb_req.pwdata[NIRQ-1:0];
            end else if (apb_req.paddr != OFS_STATUS && apb_req.paddr != OFS_IRQ_STAT) begin
                err = 1'b1;
            end
        end
        // register reads
        if (rd) begin
            if (apb_req.paddr == OFS_CTRL) begin
                rdat[CTRL_BYPASS] = s_q.bypass;
                rdat[CTRL_MODE +: 3] = s_q.mode;
            end else if (apb_req.paddr == OFS_STATUS) begin
                rdat[STAT_ARMED] = s_q.st == ST_ARMED;
                rdat[STAT_DONE] = s_q.st == ST_DONE;
            end else if (apb_req.paddr == OFS_PATTERN) begin
                rdat[NSIG*PATW-1:0] = s_q.pat;
            end else if (apb_req.paddr == OFS_BUSMATCH) begin
                rdat[2*BW-1:0] = {s_q.care, s_q.busv};
            end else if (apb_req.paddr == OFS_GROUP) begin
                rdat[8:0] = s_q.grp;
            end else if (apb_req.paddr == OFS_ADVANCED) begin
                rdat[20:0] = s_q.adv;
            end else if (apb_req.paddr == OFS_FUNCADDR) begin
                rdat = s_q.faddr;
            end else if (apb_req.paddr == OFS_IRQ_STAT) begin
                rdat[NIRQ-1:0] = s_q.ist;
            end else if (apb_req.paddr == OFS_IRQ_EN) begin
                rdat[NIRQ-1:0] = s_q.ien;
            end else begin
                err = 1'b1;
            end
        end
        // one wait state, then a single ready cycle
        s_d.rsp.pready = wr | rd;
        if (wr | rd) begin
            s_d.rsp.prdata = rdat;
            s_d.rsp.pslverr = err;
        end
        // sticky events, a new event beats a clear
        s_d.ist = (s_q.ist & ~clr) | ev;
        s_d.irq = |(s_d.ist & s_d.ien);
        // trigger and armed outputs follow the next state; store follows the current state
        s_d.trig = s_d.st == ST_DONE; // see [R2]
        s_d.arm = s_d.st == ST_ARMED; // armed leaves from its own flop
        s_d.store = (s_q.st == ST_ARMED) & ~cond & (s_q.bypass | tap.qual); // see [R1]
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0; // see [R15]
            s_q.grp <= GROUP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_rsp = s_q.rsp;
    assign trig_out = s_q.trig;
    assign store_en = s_q.store;
    assign armed = s_q.arm;
    assign irq = s_q.irq;

endmodule

`default_nettype wire

/* File: lat_trigger_eval_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// *****
// port checks
// *****
module lat_trigger_eval_chk import lat_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire lat_apb_req_s apb_req,
    input wire lat_apb_rsp_s apb_rsp,
    input wire lat_tap_s tap,
    input wire logic trig_out,
    input wire logic store_en,
    input wire logic armed,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // bus activity decode
    logic acc;
    logic any_wr;
    logic ctl_wr;
    assign acc = apb_req.psel && apb_req.penable;
    assign any_wr = apb_req.psel && apb_req.pwrite;
    assign ctl_wr = any_wr && (apb_req.paddr == OFS_CTRL);
    a_pready_answer: assert property (acc && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("pready not given on second access cycle");
    a_pready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    a_arm_by_start: assert property ($rose(armed) |-> $past(acc && ctl_wr))
        else $error("armed without a control write");
    a_trig_disarms: assert property ($rose(trig_out) |-> !armed && $past(armed))
        else $error("trigger without arming");
    a_trig_holds: assert property (trig_out && !ctl_wr |=> trig_out)
        else $error("trigger dropped without restart");
    a_arm_excl: assert property (!(armed && trig_out))
        else $error("armed and triggered together");
    a_store_armed: assert property (store_en |-> $past(armed))
        else $error("sample stored while not armed");
    a_qual_store: assert property (armed && tap.qual && !ctl_wr |=> store_en || trig_out)
        else $error("qualified sample not stored");
    a_irq_holds: assert property (irq && !any_wr |=> irq)
        else $error("interrupt dropped without a write");
endmodule
bind lat_trigger_eval lat_trigger_eval_chk chk_u (
    .clk_sys(clk_sys),
    .rst(rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .tap(tap),
    .trig_out(trig_out),
    .store_en(store_en),
    .armed(armed),
    .irq(irq)
);
`default_nettype wire

/* File: lat_tap_model.sv */
`timescale 1ns/100ps
`default_nettype none
// *****
// tapped user logic
// *****
module lat_tap_model import lat_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire lat_tap_s want,
    output var lat_tap_s tap
);
    // nodes change one cycle after the request, like user flops;
    // an address without its valid flag toggles so it is never trusted
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tap <= '0;
        end else begin
            tap <= {want.probe, want.bus_a, want.bus_b,
                    want.iaddr_valid ? want.iaddr : ~tap.iaddr,
                    want.iaddr_valid, want.qual};
        end
    end
endmodule
`default_nettype wire

/* File: tb_logic_analyzer_trigger_eval.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_logic_analyzer_trigger_eval import lat_pkg::*;;
    // *****
    // wiring and tables
    // *****
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    lat_apb_req_s req = '0;
    lat_apb_rsp_s rsp;
    lat_tap_s want = '0;
    lat_tap_s tap;
    lat_tap_s tv;
    logic trig_out;
    logic store_en;
    logic armed;
    logic irq;
    int n_fail = 0;
    int cmp_count = 0;
    logic [33:0] exp_q[$];
    logic [33:0] e_m;
    logic [7:0] r;
    logic [31:0] fa;
    // basic rows: probe pattern word, probe0/1 before and after, outcome
    logic [11:0] t_pat[9] = '{12'h0, 12'h1, 12'h2, 12'h3, 12'h4, 12'h5, 12'h5, 12'hA, 12'hA};
    logic [1:0] t_pa[9] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h3, 2'h3};
    logic [1:0] t_pb[9] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h3, 2'h3};
    logic t_ex[9] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1};
    always #10 clk_sys = ~clk_sys;
    lat_tap_model tap_u (.clk_sys(clk_sys), .rst(rst), .want(want), .tap(tap));
    lat_trigger_eval dut_u (.clk_sys(clk_sys), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .tap(tap), .trig_out(trig_out), .store_en(store_en), .armed(armed), .irq(irq));
    // *****
    // helpers
    // *****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // one bus transfer; the expected answer is queued first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        exp_q.push_back({w, e});
        @(posedge clk_sys);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'b0, a, 32'h0, {err, d});
    endtask
    function automatic lat_tap_s mk(input logic [7:0] p, input logic [7:0] a,
                                    input logic [7:0] b, input logic [31:0] ia, input logic v);
        mk = '{probe: p, bus_a: a, bus_b: b, iaddr: ia, iaddr_valid: v, qual: 1'b0};
    endfunction
    function automatic logic gred(input logic [2:0] g, input logic [3:0] v);
        case (g)
            3'h0: gred = &v;
            3'h1: gred = |v;
            3'h2: gred = ~&v;
            3'h3: gred = ~|v;
            3'h4: gred = ^v;
            3'h5: gred = ~^v;
            3'h6: gred = 1'b1;
            default: gred = 1'b0;
        endcase
    endfunction
    function automatic logic cmpf(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b);
        case (op)
            3'h0: cmpf = a < b;
            3'h1: cmpf = a <= b;
            3'h2: cmpf = a == b;
            3'h3: cmpf = a != b;
            3'h4: cmpf = a > b;
            default: cmpf = a >= b;
        endcase
    endfunction
    // arm with taps ta, switch to tb_v, then expect done or still armed
    task automatic run_case(input logic [2:0] md, input lat_tap_s ta, input lat_tap_s tb_v,
                            input logic ex);
        want <= ta;
        wr(OFS_CTRL, {27'h0, md, 2'h1});
        repeat (3) @(posedge clk_sys);
        want <= tb_v;
        repeat (4) @(posedge clk_sys);
        rd(OFS_STATUS, ex ? 32'h2 : 32'h1, 1'b0);
        chk({31'h0, trig_out}, {31'h0, ex});
    endtask
    // scoreboard: oldest note against each completed transfer
    always @(posedge clk_sys) begin
        if (rsp.pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
            end else begin
                e_m = exp_q.pop_front();
                chk({31'h0, rsp.pslverr}, {31'h0, e_m[32]});
                if (!e_m[33]) chk(rsp.prdata, e_m[31:0]);
            end
        end
    end
    // watchdog
    initial begin
        #400000;
        n_fail++;
        complete_run();
    end
    // *****
    // main sequence
    // *****
    initial begin
        void'($urandom(32'h2380));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        chk({28'h0, trig_out, store_en, armed, irq}, 32'h0);
        rd(OFS_CTRL, 32'h0, 1'b0);
        rd(OFS_GROUP, 32'h1FF, 1'b0);
        rd(OFS_IRQ_EN, 32'h0, 1'b0);
        wr(OFS_STATUS, 32'h3);
        rd(OFS_STATUS, 32'h0, 1'b0);
        rd(8'h28, 32'h0, 1'b1);
        rd(OFS_IRQ_CLR, 32'h0, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            r = 8'($urandom);
            wr(OFS_PATTERN, {20'h0, t_pat[i]});
            run_case(i == 8 ? MODE_OR : MODE_AND, mk({r[7:2], t_pa[i]}, r, r, 32'h0, 1'b0),
                mk({r[7:2], t_pb[i]}, r, r, 32'h0, 1'b0), t_ex[i]);
        end
        wr(OFS_PATTERN, 32'h0);
        wr(OFS_BUSMATCH, 32'hF0A5);
        r = 8'($urandom);
        run_case(MODE_AND, '0, mk(8'h0, {4'hA, r[3:0]}, r, 32'h0, 1'b0), 1'b1);
        run_case(MODE_AND, '0, mk(8'h0, {4'h5, r[3:0]}, r, 32'h0, 1'b0), 1'b0);
        $display("test basic done");
        wr(OFS_PATTERN, 32'h492492);
        for (int g = 0; g < 8; g++) begin
            r = 8'($urandom);
            tv = mk(r, 8'h0, 8'h0, 32'h0, 1'b0);
            wr(OFS_GROUP, {23'h0, GOP_XOR, GOP_FALSE, 3'(g)});
            run_case(MODE_GROUP, tv, tv, gred(3'(g), r[3:0]));
        end
        wr(OFS_GROUP, {23'h0, GOP_TRUE, GOP_FALSE, GOP_FALSE});
        run_case(MODE_GROUP, '0, '0, 1'b1);
        wr(OFS_GROUP, {23'h0, GOP_FALSE, GOP_TRUE, GOP_TRUE});
        run_case(MODE_GROUP, '0, '0, 1'b0);
        wr(OFS_GROUP, 32'h0);
        rd(OFS_GROUP, 32'h1C0, 1'b0);
        $display("test group done");
        for (int op = 0; op < 6; op++) begin
            r = 8'($urandom) | 8'h01;
            fa = {24'h0, op[0] ? 8'($urandom) : r};
            tv = mk(8'h0, r, fa[7:0], 32'h0, 1'b0);
            wr(OFS_ADVANCED, 32'(op) | 32'h410);
            run_case(MODE_ADV, tv, tv, cmpf(3'(op), r, fa[7:0]));
        end
        tv = mk(8'h0, 8'h5A, 8'h5A, 32'h0, 1'b0);
        wr(OFS_ADVANCED, 32'h100412);
        run_case(MODE_ADV, tv, tv, 1'b0);
        fa = $urandom;
        wr(OFS_FUNCADDR, fa);
        run_case(MODE_ADDR, '0, mk(8'h0, 8'h0, 8'h0, fa, 1'b1), 1'b1);
        run_case(MODE_ADDR, '0, mk(8'h0, 8'h0, 8'h0, fa, 1'b0), 1'b0);
        $display("test advanced done");
        wr(OFS_IRQ_EN, 32'h1);
        wr(OFS_IRQ_CLR, 32'h3);
        wr(OFS_PATTERN, 32'h0);
        wr(OFS_BUSMATCH, 32'h0);
        run_case(MODE_AND, '0, '0, 1'b1);
        chk({31'h0, irq}, 32'h1);
        rd(OFS_IRQ_STAT, 32'h3, 1'b0);
        wr(OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_EN, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_CLR, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_IRQ_STAT, 32'h2, 1'b0);
        $display("test interrupt done");
        wr(OFS_PATTERN, 32'h1);
        want <= mk(8'h1, 8'h0, 8'h0, 32'h0, 1'b0);
        wr(OFS_CTRL, 32'h3);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, store_en}, 32'h1);
        rd(OFS_CTRL, 32'h2, 1'b0);
        wr(OFS_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, store_en}, 32'h0);
        want.qual <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({31'h0, store_en}, 32'h1);
        wr(OFS_CTRL, 32'h21);
        rd(OFS_STATUS, 32'h0, 1'b0);
        chk({30'h0, trig_out, armed}, 32'h0);
        $display("test store done");
        complete_run();
    end
endmodule
`default_nettype wire
